// [shared/ptm_cfg.svh]
// Register offsets, field positions, reset values for the periodic timer.
// Assumes an 8-bit register port with byte-wide offsets.
`ifndef PTM_CFG_SVH
`define PTM_CFG_SVH
// ==========================================
// Register offsets
`define PTM_ADDR_W        4
`define PTM_OFS_CTRL0     4'h0
`define PTM_OFS_OUTCTL    4'h1
`define PTM_OFS_CAPCLR    4'h2
`define PTM_OFS_CNT_LO    4'h3
`define PTM_OFS_CNT_HI    4'h4
`define PTM_OFS_CMPA_LO   4'h5
`define PTM_OFS_CMPA_HI   4'h6
`define PTM_OFS_CMPB_LO   4'h7
`define PTM_OFS_CMPB_HI   4'h8
`define PTM_OFS_PER_LO    4'h9
`define PTM_OFS_PER_HI    4'hA
// ==========================================
// Field positions
`define PTM_CTRL0_ON      3
`define PTM_CTRL0_PAUSE   7
`define PTM_OC_CLRSEL     0
`define PTM_OC_CAPSRC     1
`define PTM_OC_INVERT     2
`define PTM_OC_INIT       3
`define PTM_RESET_BYTE    8'h00
`define PTM_CNT_W         10
`endif

// [shared/ptm_pkg.sv]
// Types shared by the periodic timer design.
// Assumes ptm_cfg.svh constants are included by users.
package ptm_pkg;
  // ==========================================
  // Modes and pin functions
  typedef enum logic [1:0]
  {
    PTM_MODE_CMP = 2'b00,
    PTM_MODE_CAP = 2'b01,
    PTM_MODE_PWM = 2'b10,
    PTM_MODE_TMR = 2'b11
  } ptm_mode_type;

  typedef struct packed
  {
    logic [1:0] mode;
    logic [1:0] pin_function_select;
    logic       output_initial_level;
    logic       output_invert;
    logic       capture_source_select;
    logic       counter_clear_select;
  } ptm_outctl_type;

  typedef struct packed
  {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ptm_bus_type;
endpackage

// [hdl/ptm_edge_det.sv]
// Rising and falling edge detector for a synchronous level.
// Assumes the input is already synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module ptm_edge_det
(
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic level,
  output logic      rise,
  output logic      fall
);
  logic prev;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      prev <= 1'b0;
    else
      prev <= level;
  end

  assign rise = level & ~prev;
  assign fall = ~level & prev;
endmodule
`default_nettype wire

// [hdl/ptm_core.sv]
// Periodic timer: 10-bit counter, compare A/P, capture into A/B, output pin.
// Assumes one clock; tick and pins synchronous to clk; byte register port.
`timescale 1ns/1ps
`default_nettype none
`include "ptm_cfg.svh"
module ptm_core
  import ptm_pkg::*;
#(
  parameter int CNT_W = `PTM_CNT_W
)
(
  input  wire logic                   clk,
  input  wire logic                   sys_rst,
  input  wire logic [`PTM_ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]             reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [7:0]             reg_rdata,
  input  wire logic                   count_tick,
  input  wire logic                   timer_external_pin,
  input  wire logic                   line_comparator_output,
  output logic                        timer_output_pin,
  output logic                        timer_output_enable,
  output logic                        match_a_event,
  output logic                        match_p_event
);
  // ==========================================
  // Registers
  logic [7:0]       ctrl0;
  ptm_outctl_type   oc;
  logic [1:0]       capture_clear_select;
  logic             latch_edge_flag;
  logic [CNT_W-1:0] counter;
  logic [CNT_W-1:0] compare_a_value;
  logic [CNT_W-1:0] compare_b_value;
  logic [CNT_W-1:0] period_value;
  logic             out_level;
  logic             pulse_active;
  logic             on_prev;

  ptm_mode_type     mode;
  logic             counter_on;
  logic             paused;
  logic             on_rise;
  logic             running;
  logic             cap_in;
  logic             cap_rise;
  logic             cap_fall;
  logic             hit_a;
  logic             hit_p;
  logic             overflow;
  logic             clr_a_sel;
  logic             do_clear;
  logic             latch_a;
  logic             latch_b;
  logic             cap_clear;
  logic             pulse_stop;
  logic             next_out_level;
  logic             pwm_wave;
  logic             raw_out;

  assign mode       = ptm_mode_type'(oc.mode);
  assign counter_on = ctrl0[`PTM_CTRL0_ON];
  assign paused     = ctrl0[`PTM_CTRL0_PAUSE];
  assign on_rise    = counter_on & ~on_prev;
  assign running    = counter_on & ~paused & count_tick;

  // ==========================================
  // Capture input
  assign cap_in = oc.capture_source_select ? timer_external_pin : line_comparator_output;

  ptm_edge_det u_cap_edge
  (
    .clk     (clk),
    .sys_rst (sys_rst),
    .level   (cap_in),
    .rise    (cap_rise),
    .fall    (cap_fall)
  );

  always_comb
  begin
    latch_a = 1'b0;
    latch_b = 1'b0;
    if (mode == PTM_MODE_CAP && counter_on)
    begin
      if (capture_clear_select == 2'h0)
      begin
        case (oc.pin_function_select)
          2'h0:    latch_a = cap_rise;
          2'h1:    latch_a = cap_fall;
          2'h2:    latch_a = cap_rise | cap_fall;
          default: latch_a = 1'b0;
        endcase
      end
      else
      begin
        case (oc.pin_function_select)
          2'h0:    latch_b = cap_rise;
          2'h1:    latch_a = cap_fall;
          2'h2:
          begin
            latch_a = cap_fall;
            latch_b = cap_rise;
          end
          default: latch_a = 1'b0;
        endcase
      end
    end
  end

  always_comb
  begin
    cap_clear = 1'b0;
    if (mode == PTM_MODE_CAP && counter_on)
    begin
      case (capture_clear_select)
        2'h1:    cap_clear = cap_rise;
        2'h2:    cap_clear = cap_fall;
        2'h3:    cap_clear = cap_rise | cap_fall;
        default: cap_clear = 1'b0;
      endcase
    end
  end

  // ==========================================
  // Comparators and counter clear
  assign hit_a    = running && (counter == compare_a_value);
  assign hit_p    = running && (counter == period_value);
  assign overflow = running && (counter == {CNT_W{1'b1}});
  assign clr_a_sel = oc.counter_clear_select &&
                     (mode == PTM_MODE_CMP || mode == PTM_MODE_TMR);

  always_comb
  begin
    if (clr_a_sel)
      do_clear = hit_a;
    else if (period_value == '0)
      do_clear = overflow;
    else
      do_clear = hit_p;
  end

  assign pulse_stop = (mode == PTM_MODE_PWM) && (oc.pin_function_select == 2'h3) && hit_a;
  assign match_a_event = hit_a && !(compare_a_value == '0 && mode != PTM_MODE_PWM);
  assign match_p_event = hit_p && !clr_a_sel;

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      on_prev <= 1'b0;
    else
      on_prev <= counter_on;
  end

  // Pre-clear value is latched in the same cycle as the clear
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      counter <= '0;
    else if (on_rise)
      counter <= '0;
    else if (cap_clear)
      counter <= '0;
    else if (running && mode != PTM_MODE_PWM)
      counter <= do_clear ? '0 : counter + CNT_W'(1);
    // Period zero means a full-range cycle, so only the natural wrap clears
    else if (running)
      counter <= (hit_p && period_value != '0) ? '0 : counter + CNT_W'(1);
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      latch_edge_flag <= 1'b0;
    else if (latch_a || latch_b)
      latch_edge_flag <= cap_rise;
  end

  // ==========================================
  // Register writes and capture loads
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ctrl0                <= `PTM_RESET_BYTE;
      oc                   <= ptm_outctl_type'(`PTM_RESET_BYTE);
      capture_clear_select <= 2'h0;
      period_value         <= '0;
    end
    else
    begin
      if (reg_wr)
      begin
        case (reg_addr)
          `PTM_OFS_CTRL0:  ctrl0 <= {reg_wdata[7:3], 3'h0};
          `PTM_OFS_OUTCTL: oc <= ptm_outctl_type'(reg_wdata);
          `PTM_OFS_CAPCLR: capture_clear_select <= reg_wdata[2:1];
          `PTM_OFS_PER_LO: period_value[7:0] <= reg_wdata;
          `PTM_OFS_PER_HI: period_value[CNT_W-1:8] <= reg_wdata[CNT_W-9:0];
          default:         ctrl0 <= ctrl0;
        endcase
      end
      // Pulse end beats a same-cycle control write, other writes still land
      if (pulse_stop)
        ctrl0[`PTM_CTRL0_ON] <= 1'b0;
    end
  end

  // Capture wins over a software write in the same cycle
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      compare_a_value <= '0;
      compare_b_value <= '0;
    end
    else
    begin
      if (latch_a)
        compare_a_value <= counter;
      else if (reg_wr && reg_addr == `PTM_OFS_CMPA_LO)
        compare_a_value[7:0] <= reg_wdata;
      else if (reg_wr && reg_addr == `PTM_OFS_CMPA_HI)
        compare_a_value[CNT_W-1:8] <= reg_wdata[CNT_W-9:0];
      if (latch_b)
        compare_b_value <= counter;
      else if (reg_wr && reg_addr == `PTM_OFS_CMPB_LO)
        compare_b_value[7:0] <= reg_wdata;
      else if (reg_wr && reg_addr == `PTM_OFS_CMPB_HI)
        compare_b_value[CNT_W-1:8] <= reg_wdata[CNT_W-9:0];
    end
  end

  // ==========================================
  // Output stage
  always_comb
  begin
    next_out_level = out_level;
    if (on_rise)
      next_out_level = oc.output_initial_level;
    else if (mode == PTM_MODE_CMP && match_a_event)
    begin
      case (oc.pin_function_select)
        2'h1:    next_out_level = 1'b0;
        2'h2:    next_out_level = 1'b1;
        2'h3:    next_out_level = ~out_level;
        default: next_out_level = out_level;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      out_level <= 1'b0;
    else
      out_level <= next_out_level;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      pulse_active <= 1'b0;
    else if (on_rise)
      pulse_active <= 1'b1;
    else if (!counter_on || pulse_stop)
      pulse_active <= 1'b0;
  end

  // Duty at or above the period gives a full-on wave
  assign pwm_wave = (counter < compare_a_value) ||
                    (period_value != '0 && compare_a_value >= period_value);

  always_comb
  begin
    raw_out = out_level;
    if (mode == PTM_MODE_PWM)
    begin
      case (oc.pin_function_select)
        2'h0:    raw_out = ~oc.output_initial_level;
        2'h1:    raw_out = oc.output_initial_level;
        2'h2:    raw_out = pwm_wave ? oc.output_initial_level : ~oc.output_initial_level;
        default: raw_out = pulse_active ? oc.output_initial_level : ~oc.output_initial_level;
      endcase
    end
  end

  // Pin is undriven in capture and timer modes, so polarity has no effect there
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      timer_output_pin    <= 1'b0;
      timer_output_enable <= 1'b0;
    end
    else
    begin
      timer_output_pin    <= raw_out ^ oc.output_invert;
      timer_output_enable <= (mode == PTM_MODE_CMP) || (mode == PTM_MODE_PWM);
    end
  end

  // ==========================================
  // Register reads
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        `PTM_OFS_CTRL0:   reg_rdata <= ctrl0;
        `PTM_OFS_OUTCTL:  reg_rdata <= oc;
        `PTM_OFS_CAPCLR:  reg_rdata <= {5'h00, capture_clear_select, latch_edge_flag};
        `PTM_OFS_CNT_LO:  reg_rdata <= counter[7:0];
        `PTM_OFS_CNT_HI:  reg_rdata <= {6'h00, counter[9:8]};
        `PTM_OFS_CMPA_LO: reg_rdata <= compare_a_value[7:0];
        `PTM_OFS_CMPA_HI: reg_rdata <= {6'h00, compare_a_value[9:8]};
        `PTM_OFS_CMPB_LO: reg_rdata <= compare_b_value[7:0];
        `PTM_OFS_CMPB_HI: reg_rdata <= {6'h00, compare_b_value[9:8]};
        `PTM_OFS_PER_LO:  reg_rdata <= period_value[7:0];
        `PTM_OFS_PER_HI:  reg_rdata <= {6'h00, period_value[9:8]};
        default:          reg_rdata <= 8'h00;
      endcase
    end
    else
      reg_rdata <= 8'h00;
  end
endmodule
`default_nettype wire

// [verif/ptm_core_props.sv]
// Port checker for ptm_core, bound to every instance.
// Assumes single clk domain and async active-high sys_rst.
`timescale 1ns/1ps
`default_nettype none
module ptm_core_props
(
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       timer_output_pin,
  input wire logic       timer_output_enable,
  input wire logic       match_a_event
);
  logic [7:0] oc;
  logic       on;
  logic [2:0] q;
  logic       st;
  logic       ma_ok;
  logic       on_rise;
  // ==========================================
  // Shadow of control writes
  // Single pulse self-clear is not tracked, so assertions use on outside it only
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      oc <= 8'h00;
      on <= 1'b0;
      q  <= 3'h0;
    end
    else
    begin
      if (reg_wr && reg_addr == 4'h1)
        oc <= reg_wdata;
      if (reg_wr && reg_addr == 4'h0)
        on <= reg_wdata[3];
      if (reg_wr && reg_addr <= 4'h1)
        q <= 3'h0;
      else if (q != 3'h7)
        q <= q + 3'h1;
    end
  end
  // Settled: no control write for three cycles
  assign st      = (q >= 3'h3);
  assign ma_ok   = st && on && match_a_event;
  assign on_rise = st && !on && oc[7:6] == 2'b00 && reg_wr && reg_addr == 4'h0 && reg_wdata[3];
  // ==========================================
  // Assertions
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  a_ctrl0_low: assert property (reg_rd && reg_addr == 4'h0 |=> reg_rdata[2:0] == 3'h0)
    else $error("control low bits not zero");
  a_clear_top: assert property (reg_rd && reg_addr == 4'h2 |=> reg_rdata[7:3] == 5'h00)
    else $error("capture clear top bits not zero");
  a_high_bytes: assert property (reg_rd && reg_addr inside {4'h4, 4'h6, 4'h8, 4'hA} |=> reg_rdata[7:2] == 6'h00)
    else $error("high byte top bits not zero");
  a_oe_mode: assert property (st |-> timer_output_enable == !oc[6])
    else $error("output enable wrong for mode");
  a_pin_hold: assert property (st && oc[7:4] == 4'h0 |=> $stable(timer_output_pin))
    else $error("pin moved with no change selected");
  a_match_set: assert property (ma_ok && oc[7:4] == 4'h2 |-> ##[1:3] timer_output_pin == !oc[2])
    else $error("match did not drive high");
  a_match_clr: assert property (ma_ok && oc[7:4] == 4'h1 |-> ##[1:3] timer_output_pin == oc[2])
    else $error("match did not drive low");
  a_on_init: assert property (on_rise |-> ##[1:3] timer_output_pin == (oc[3] ^ oc[2]))
    else $error("counter on did not restore level");
  a_pwm_force: assert property (st && on && oc[7:5] == 3'b100 |-> timer_output_pin == ((oc[4] ~^ oc[3]) ^ oc[2]))
    else $error("forced pwm level wrong");
  c_match: cover property (ma_ok);
  c_capture: cover property (st && oc[7:6] == 2'b01);
  c_pwm: cover property (st && on && oc[7:6] == 2'b10);
endmodule
bind ptm_core ptm_core_props u_ptm_core_props
(
  .clk(clk),
  .sys_rst(sys_rst),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .timer_output_pin(timer_output_pin),
  .timer_output_enable(timer_output_enable),
  .match_a_event(match_a_event)
);
`default_nettype wire

// [verif/ptm_pin_model.sv]
// Far side: external timer pin and line comparator levels.
// Assumes the bench asks for levels; they reach the block a cycle later.
`timescale 1ns/1ps
`default_nettype none
module ptm_pin_model
(
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic want_ext,
  input  wire logic want_cmp,
  output logic      timer_external_pin,
  output logic      line_comparator_output
);
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      timer_external_pin     <= 1'b0;
      line_comparator_output <= 1'b0;
    end
    else
    begin
      timer_external_pin     <= want_ext;
      line_comparator_output <= want_cmp;
    end
  end
endmodule
`default_nettype wire

// [verif/ptm_core_tb_top.sv]
// Bench for ptm_core: registers, compare output, clearing, capture.
// Assumes the checker bind and pin model are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module ptm_core_tb_top;
  logic       clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic       count_tick = 1'b0;
  logic       want_ext = 1'b0;
  logic       want_cmp = 1'b0;
  logic [7:0] d;
  wire  [7:0] reg_rdata;
  wire        ext, cmp, pin, ma, mp;
  int         error_cnt = 0;
  int         total_checks = 0;
  int         i, pa, pp;
  // Rows: address, write value, read-back value
  logic [19:0] rows [12] = '{20'h5FFFF, 20'h6FF03, 20'h7A5A5, 20'h8FF03, 20'h93C3C, 20'hAFF03,
                             20'h2FF06, 20'h3FF00, 20'h4FF00, 20'hBFF00, 20'h08780, 20'h1C5C5};
  // Compare cases: output control, level before match, level after
  logic [9:0]  cr [5] = '{10'h081, 10'h062, 10'h0D2, 10'h0A3, 10'h023};
  always #12.5 clk = ~clk;
  ptm_core u_ptm_core
  (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .count_tick(count_tick),
    .timer_external_pin(ext), .line_comparator_output(cmp), .timer_output_pin(pin),
    .timer_output_enable(), .match_a_event(ma), .match_p_event(mp)
  );
  ptm_pin_model u_ptm_pin_model
  (
    .clk(clk), .sys_rst(sys_rst), .want_ext(want_ext), .want_cmp(want_cmp),
    .timer_external_pin(ext), .line_comparator_output(cmp)
  );
  // ==========================================
  // Tasks
  task automatic check(input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
    check(exp, d);
  endtask
  // Counter off, program, then a clean on edge
  task automatic start(input logic [7:0] oc);
    wr(4'h0, 8'h00);
    wr(4'h1, oc);
    repeat (3) @(posedge clk);
    wr(4'h0, 8'h08);
  endtask
  task automatic count_ev(input int n);
    pa = 0;
    pp = 0;
    repeat (n)
    begin
      @(posedge clk);
      #1;
      pa += int'(ma);
      pp += int'(mp);
    end
  endtask
  task automatic tick(input int n);
    @(posedge clk);
    count_tick <= 1'b1;
    repeat (n) @(posedge clk);
    count_tick <= 1'b0;
  endtask
  task automatic edge_wait;
    repeat (5) @(posedge clk);
  endtask
  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Run is under 500 cycles; allow eight times that
  initial
  begin
    #100000;
    error_cnt++;
    complete_run;
  end
  // ==========================================
  // Main sequence
  initial
  begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    for (int k = 0; k <= 10; k++)
      rdchk(4'(k), 8'h00);
    foreach (rows[k])
    begin
      wr(rows[k][19:16], rows[k][15:8]);
      rdchk(rows[k][19:16], rows[k][7:0]);
    end
    wr(4'h5, 8'h0A);
    wr(4'h6, 8'h00);
    wr(4'h9, 8'h14);
    wr(4'hA, 8'h00);
    wr(4'h2, 8'h00);
    @(posedge clk);
    count_tick <= 1'b1;
    foreach (cr[k])
    begin
      start(cr[k][9:2]);
      repeat (3) @(posedge clk);
      #1;
      check(8'(cr[k][1]), 8'(pin));
      i = 0;
      while (ma !== 1'b1 && i < 40)
      begin
        @(posedge clk);
        #1;
        i++;
      end
      check(8'h01, 8'(i < 40));
      repeat (3) @(posedge clk);
      #1;
      check(8'(cr[k][0]), 8'(pin));
    end
    start(8'h21);
    count_ev(60);
    check(8'h00, 8'(pp));
    check(8'h01, 8'(pa > 0));
    start(8'h99);
    count_ev(60);
    check(8'h01, 8'(pp > 0));
    check(8'h01, 8'(pin));
    start(8'h89);
    count_ev(8);
    check(8'h00, 8'(pin));
    @(posedge clk);
    count_tick <= 1'b0;
    wr(4'h9, 8'hFF);
    wr(4'hA, 8'h03);
    wr(4'h2, 8'h06);
    start(8'h62);
    tick(7);
    rdchk(4'h3, 8'h07);
    @(posedge clk);
    want_ext <= 1'b1;
    edge_wait;
    rdchk(4'h7, 8'h07);
    rdchk(4'h3, 8'h00);
    rdchk(4'h2, 8'h07);
    tick(3);
    want_ext <= 1'b0;
    edge_wait;
    rdchk(4'h5, 8'h03);
    rdchk(4'h2, 8'h06);
    tick(2);
    want_cmp <= 1'b1;
    edge_wait;
    rdchk(4'h7, 8'h07);
    want_cmp <= 1'b0;
    edge_wait;
    wr(4'h1, 8'h60);
    @(posedge clk);
    want_cmp <= 1'b1;
    edge_wait;
    rdchk(4'h7, 8'h02);
    // Rising-only clear: a falling latch must keep the count
    wr(4'h2, 8'h02);
    tick(4);
    want_cmp <= 1'b0;
    edge_wait;
    rdchk(4'h5, 8'h04);
    rdchk(4'h3, 8'h04);
    rdchk(4'h2, 8'h02);
    complete_run;
  end
endmodule
`default_nettype wire
